//--- logic/sync_serial_port.sv
// How it works
// - spi master clock: fosc/4,/16,/64 or timer2/2
// - spi slave uses pin clock, select optional
// - codes 0110/0111 give 7/10-bit i2c slave
// - i2c master baud is fosc/(4*(baud+1))
// - firmware master codes; four codes reserved
// - enable bit hands pins to port
// - spi clock idles at polarity bit level
// - i2c slave stretches clock while polarity low
// - transmit edge rising when edge differs polarity
// - spi master: sample bit picks end or middle sampling
// - i2c: sample bit controls slew rate
// - i2c: edge bit picks smbus input levels
// - data/address flag tracks last byte kind
// - stop flag, cleared by reset or disable
// - start flag, cleared by reset or disable
// - read/write bit; master: transmit in progress
// - update-address flag in 10-bit slave mode
// - buffer full set on receive, cleared empty
// - i2c transmit keeps buffer full until done
// - write collision on busy buffer write, sticky
// - spi slave overflow drops byte, never master
// - i2c overflow when byte lands on full buffer
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "ssp_map.svh"
module sync_serial_port (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // register port
  input  wire logic [7:0]    addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr_stb,
  input  wire logic          rd_stb,
  output logic      [7:0]    rdata,
  // events from the shift engine, same clock
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_byte,
  input  wire logic          rx_is_data,
  input  wire logic          tx_done,
  input  wire logic          tx_is_data,
  input  wire logic          start_det,
  input  wire logic          stop_det,
  input  wire logic          addr_match,
  input  wire logic          addr_rw,
  input  wire logic          nack_det,
  input  wire logic          ua_req,
  input  wire logic          timer2_tick,
  // serial clock pin and slave select pin
  input  wire logic          sck_i,
  output logic               sck_o,
  output logic               sck_oe,
  input  wire logic          ss_n_i,
  // configuration toward shift engine and pads
  output ssp_pkg::mode_t     mode,
  output logic               pins_to_port,
  output logic               spi_master,
  output logic               spi_slave,
  output logic               i2c_slave,
  output logic               i2c_master,
  output logic               i2c_fw_master,
  output logic               ten_bit_addr,
  output logic               start_stop_irq_en,
  output logic               slave_selected,
  output logic               sck_level,
  output logic               tx_on_rising,
  output logic               sample_at_end,
  output logic               slew_ctrl_en,
  output logic               smbus_levels,
  // transfer handshakes
  output logic               tx_load,
  output logic      [7:0]    tx_byte,
  output logic               sck_edge,
  output logic               i2c_baud_tick
);
  import ssp_pkg::*;

  // ==========================================================
  // mode decoding
  function automatic logic is_spi_m(input logic [3:0] m);
    is_spi_m = (m[3:2] == 2'b00);
  endfunction

  function automatic logic is_spi_s(input logic [3:0] m);
    is_spi_s = (m == MODE_SPI_S_SS) || (m == MODE_SPI_S_NOSS);
  endfunction

  function automatic logic is_i2c_s(input logic [3:0] m);
    is_i2c_s = (m == MODE_I2C_S_7) || (m == MODE_I2C_S_10);
  endfunction

  // reserved codes fall out of every class, so the port stays passive
  function automatic logic is_i2c_m(input logic [3:0] m);
    is_i2c_m = (m == MODE_I2C_M) || (m == MODE_I2C_FW_IDLE) ||
               (m == MODE_I2C_FW_7) || (m == MODE_I2C_FW_10);
  endfunction

  // ==========================================================
  // registers
  logic [7:0]  ctrl_r;
  logic        smp_r;
  logic        cke_r;
  logic        da_r;
  logic        stop_r;
  logic        start_r;
  logic        slv_rw_r;
  logic        ua_r;
  logic        bf_r;
  logic [7:0]  buf_r;
  logic [7:0]  baud_r;
  logic [4:0]  seq_r;
  logic        tx_busy_r;
  logic [1:0]  sck_sync_r;
  logic [1:0]  ss_sync_r;
  sck_state_t  sck_state_r;
  logic [3:0]  edge_cnt_r;
  logic        sck_r;

  logic [3:0]  m;
  logic        en;
  logic        clock_polarity;
  logic        sm;
  logic        ss;
  logic        im;
  logic        is;
  logic        i2c;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_buf;
  logic        wr_baud;
  logic        wr_seq;
  logic        rd_buf;
  logic        collide;
  logic        buf_accept;
  logic        rx_take;
  logic        rx_ovf;
  logic        div_run;
  logic [9:0]  half;
  logic        div_tick;
  logic        run_tick;

  assign m   = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign en  = ctrl_r[`CTRL_EN];
  assign clock_polarity = ctrl_r[`CTRL_CKP];
  assign sm  = en && is_spi_m(m);
  assign ss  = en && is_spi_s(m);
  assign is  = en && is_i2c_s(m);
  assign im  = en && is_i2c_m(m);
  assign i2c = is || im;

  assign wr_ctrl = wr_stb && (addr == `CTRL_ADDR);
  assign wr_stat = wr_stb && (addr == `STAT_ADDR);
  assign wr_buf  = wr_stb && (addr == `BUF_ADDR);
  assign wr_baud = wr_stb && (addr == `BAUD_ADDR);
  assign wr_seq  = wr_stb && (addr == `SEQ_ADDR);
  assign rd_buf  = rd_stb && (addr == `BUF_ADDR);

  // master busy or bus sequence running, or previous word still shifting
  assign collide    = tx_busy_r || (im && (seq_r != 5'h00));
  assign buf_accept = wr_buf && !collide;
  assign rx_take    = rx_valid && (sm || ss || i2c);
  assign rx_ovf     = rx_take && bf_r && !sm;

  // ==========================================================
  // control register
  // software may rewrite the mode at any time; a live transfer is not fenced off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata;
      end
      if (wr_buf && collide) begin
        ctrl_r[`CTRL_WRITE_COLLISION] <= 1'b1;
      end
      if (rx_ovf) begin
        ctrl_r[`CTRL_OVF] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // status: configuration bits and bus condition flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_r <= 1'(`STAT_RST >> `STAT_SMP);
      cke_r <= 1'b0;
    end else if (wr_stat) begin
      smp_r <= wdata[`STAT_SMP];
      cke_r <= wdata[`STAT_CKE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= 1'b0;
      stop_r  <= 1'b0;
    end else if (!en) begin
      start_r <= 1'b0;
      stop_r  <= 1'b0;
    end else if (i2c && stop_det) begin
      start_r <= 1'b0;
      stop_r  <= 1'b1;
    end else if (i2c && start_det) begin
      start_r <= 1'b1;
      stop_r  <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      da_r <= 1'b0;
    end else if (i2c && rx_take) begin
      da_r <= rx_is_data;
    end else if (i2c && tx_done) begin
      da_r <= tx_is_data;
    end
  end

  // slave read/write bit lives from address match to next start, stop or nack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slv_rw_r <= 1'b0;
    end else if (is && addr_match) begin
      slv_rw_r <= addr_rw;
    end else if (start_det || stop_det || nack_det) begin
      slv_rw_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ua_r <= 1'b0;
    end else if (is && (m == MODE_I2C_S_10) && ua_req) begin
      ua_r <= 1'b1;
    end else if (wr_baud) begin
      ua_r <= 1'b0;
    end
  end

  // ==========================================================
  // buffer, buffer full and transmit tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r <= `BUF_RST;
    end else if (buf_accept) begin
      buf_r <= wdata;
    end else if (rx_take && !rx_ovf) begin
      buf_r <= rx_byte;
    end
  end

  // a load wins over a read or a transmit end in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bf_r <= 1'b0;
    end else if (!en) begin
      bf_r <= 1'b0;
    end else if ((rx_take && !rx_ovf) || (buf_accept && i2c)) begin
      bf_r <= 1'b1;
    end else if (rd_buf || (i2c && tx_done)) begin
      bf_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_r <= 1'b0;
    end else if (!en) begin
      tx_busy_r <= 1'b0;
    end else if (buf_accept) begin
      tx_busy_r <= 1'b1;
    end else if (tx_done || (sck_state_r == SCK_DONE)) begin
      tx_busy_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_load <= 1'b0;
      tx_byte <= `BUF_RST;
    end else begin
      tx_load <= buf_accept && en;
      if (buf_accept) begin
        tx_byte <= wdata;
      end
    end
  end

  // ==========================================================
  // baud and sequence-enable registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_r <= `BAUD_RST;
    end else if (wr_baud) begin
      baud_r <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= `SEQ_RST;
    end else if (wr_seq) begin
      seq_r <= wdata[4:0];
    end
  end

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_sync_r <= 2'b00;
      ss_sync_r  <= 2'b11;
    end else begin
      sck_sync_r <= {sck_sync_r[0], sck_i};
      ss_sync_r  <= {ss_sync_r[0], ss_n_i};
    end
  end

  // ==========================================================
  // clock dividers: one counter shared by spi and i2c master
  always_comb begin
    case (m)
      MODE_SPI_M_DIV4:  half = `HALF_DIV4;
      MODE_SPI_M_DIV16: half = `HALF_DIV16;
      MODE_SPI_M_DIV64: half = `HALF_DIV64;
      default:          half = {1'b0, baud_r, 1'b0} + 10'h002;
    endcase
  end

  assign div_run  = (sm && (sck_state_r == SCK_RUN)) || (en && (m == MODE_I2C_M));
  assign run_tick = (m == MODE_SPI_M_TIMER2_COUNT) ? timer2_tick : div_tick;

  ssp_tick_div #(
    .W (10)
  ) u_div (
    .clk         (clk),
    .rst_n       (rst_n),
    .run         (div_run),
    .half_period (half),
    .tick        (div_tick)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_baud_tick <= 1'b0;
    end else begin
      i2c_baud_tick <= en && (m == MODE_I2C_M) && div_tick;
    end
  end

  // ==========================================================
  // spi master serial clock: sixteen edges per byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_state_r <= SCK_IDLE;
      edge_cnt_r  <= 4'h0;
      sck_r       <= 1'b0;
      sck_edge    <= 1'b0;
    end else begin
      sck_edge <= 1'b0;
      case (sck_state_r)
        SCK_IDLE: begin
          sck_r      <= clock_polarity;
          edge_cnt_r <= 4'h0;
          if (sm && buf_accept) begin
            sck_state_r <= SCK_RUN;
          end
        end
        SCK_RUN: begin
          if (!sm) begin
            sck_state_r <= SCK_IDLE;
          end else if (run_tick) begin
            sck_r      <= ~sck_r;
            sck_edge   <= 1'b1;
            edge_cnt_r <= edge_cnt_r + 4'h1;
            if (edge_cnt_r == `SCK_EDGES_LAST) begin
              sck_state_r <= SCK_DONE;
            end
          end
        end
        SCK_DONE: begin
          sck_state_r <= SCK_IDLE;
        end
        default: begin
          sck_state_r <= SCK_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin drive and configuration outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_o  <= 1'b0;
      sck_oe <= 1'b0;
    end else if (sm) begin
      sck_o  <= sck_r;
      sck_oe <= 1'b1;
    end else if (is && !clock_polarity) begin
      sck_o  <= 1'b0;
      sck_oe <= 1'b1;
    end else begin
      sck_o  <= 1'b0;
      sck_oe <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode              <= MODE_SPI_M_DIV4;
      pins_to_port      <= 1'b0;
      spi_master        <= 1'b0;
      spi_slave         <= 1'b0;
      i2c_slave         <= 1'b0;
      i2c_master        <= 1'b0;
      i2c_fw_master     <= 1'b0;
      ten_bit_addr      <= 1'b0;
      start_stop_irq_en <= 1'b0;
      slave_selected    <= 1'b0;
      sck_level         <= 1'b0;
      tx_on_rising      <= 1'b0;
      sample_at_end     <= 1'b0;
      slew_ctrl_en      <= 1'b0;
      smbus_levels      <= 1'b0;
    end else begin
      mode              <= mode_t'(m);
      pins_to_port      <= en;
      spi_master        <= sm;
      spi_slave         <= ss;
      i2c_slave         <= is;
      i2c_master        <= en && (m == MODE_I2C_M);
      i2c_fw_master     <= im && (m != MODE_I2C_M);
      ten_bit_addr      <= en && ((m == MODE_I2C_S_10) || (m == MODE_I2C_FW_10));
      start_stop_irq_en <= en && (m[3:1] == 3'b111);
      slave_selected    <= ss && ((m == MODE_SPI_S_NOSS) || !ss_sync_r[1]);
      sck_level         <= sck_sync_r[1];
      tx_on_rising      <= cke_r ^ clock_polarity;
      sample_at_end     <= sm && smp_r;
      slew_ctrl_en      <= i2c && !smp_r;
      smbus_levels      <= i2c && cke_r;
    end
  end

  // ==========================================================
  // register read port: data only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        `CTRL_ADDR: rdata <= ctrl_r;
        `STAT_ADDR: rdata <= {smp_r, cke_r, da_r, stop_r, start_r,
                              (im ? tx_busy_r : slv_rw_r), ua_r, bf_r};
        `BUF_ADDR:  rdata <= buf_r;
        `BAUD_ADDR: rdata <= baud_r;
        `SEQ_ADDR:  rdata <= {3'h0, seq_r};
        default:    rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

//--- logic/ssp_map.svh
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
// ==========================================================
// register offsets
`define CTRL_ADDR      8'h14
`define STAT_ADDR      8'h94
`define BUF_ADDR       8'h13
`define BAUD_ADDR      8'h93
`define SEQ_ADDR       8'h91
// ==========================================================
// control register fields
`define CTRL_WRITE_COLLISION      7
`define CTRL_OVF       6
`define CTRL_EN        5
`define CTRL_CKP       4
`define CTRL_MODE_HI   3
`define CTRL_MODE_LO   0
// ==========================================================
// status register fields
`define STAT_SMP       7
`define STAT_CKE       6
`define STAT_DA        5
`define STAT_STOP      4
`define STAT_START     3
`define STAT_RW        2
`define STAT_UA        1
`define STAT_BF        0
// ==========================================================
// reset values
`define CTRL_RST       8'h00
`define STAT_RST       8'h00
`define BUF_RST        8'h00
`define BAUD_RST       8'h00
`define SEQ_RST        5'h00
// ==========================================================
// serial clock half periods in system clocks (fosc/4, /16, /64)
`define HALF_DIV4      10'h002
`define HALF_DIV16     10'h008
`define HALF_DIV64     10'h020
`define SCK_EDGES_LAST 4'hf
`endif

//--- logic/ssp_pkg.sv
package ssp_pkg;
  // ==========================================================
  // mode field codes
  typedef enum logic [3:0] {
    MODE_SPI_M_DIV4  = 4'h0,
    MODE_SPI_M_DIV16 = 4'h1,
    MODE_SPI_M_DIV64 = 4'h2,
    MODE_SPI_M_TIMER2_COUNT  = 4'h3,
    MODE_SPI_S_SS    = 4'h4,
    MODE_SPI_S_NOSS  = 4'h5,
    MODE_I2C_S_7     = 4'h6,
    MODE_I2C_S_10    = 4'h7,
    MODE_I2C_M       = 4'h8,
    MODE_RSVD_9      = 4'h9,
    MODE_RSVD_A      = 4'ha,
    MODE_I2C_FW_IDLE = 4'hb,
    MODE_RSVD_C      = 4'hc,
    MODE_RSVD_D      = 4'hd,
    MODE_I2C_FW_7    = 4'he,
    MODE_I2C_FW_10   = 4'hf
  } mode_t;
  // ==========================================================
  // spi master clock sequencer
  typedef enum logic [2:0] {
    SCK_IDLE = 3'b001,
    SCK_RUN  = 3'b010,
    SCK_DONE = 3'b100
  } sck_state_t;
endpackage

//--- logic/ssp_tick_div.sv
`timescale 1ns/10ps
// ==========================================================
// half-period tick generator; restarts whenever run drops
module ssp_tick_div #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] half_period,
  // result
  output logic              tick
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r + W'(1) >= half_period) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + W'(1);
      tick  <= 1'b0;
    end
  end
endmodule

//--- testbench/sync_serial_port_properties.sv
`timescale 1ns/10ps
`include "ssp_map.svh"
// ==========================================================
// port checker
module sync_serial_port_properties (
  // clock and reset
  input wire logic           clk,
  input wire logic           rst_n,
  // register port
  input wire logic [7:0]     addr,
  input wire logic [7:0]     wdata,
  input wire logic           wr_stb,
  input wire logic           rd_stb,
  input wire logic [7:0]     rdata,
  // outputs watched
  input wire logic           sck_o,
  input wire logic           sck_oe,
  input wire ssp_pkg::mode_t mode,
  input wire logic           pins_to_port,
  input wire logic           spi_master,
  input wire logic           i2c_slave,
  input wire logic           i2c_master,
  input wire logic           i2c_fw_master,
  input wire logic           tx_on_rising,
  input wire logic           sample_at_end,
  input wire logic           slew_ctrl_en,
  input wire logic           smbus_levels,
  input wire logic           sck_edge
);
  import ssp_pkg::*;
  logic [5:0] ctl_h;
  logic [1:0] st_h;
  logic [9:0] quiet;
  logic       i2c_any;
  assign i2c_any = i2c_slave | i2c_master | i2c_fw_master;
  // mirror of the software-owned control and status bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_h <= '0;
      st_h <= '0;
    end else if (wr_stb && addr == `CTRL_ADDR) begin
      ctl_h <= wdata[5:0];
    end else if (wr_stb && addr == `STAT_ADDR) begin
      st_h <= wdata[7:6];
    end
  end
  // cycles since a buffer or control write; a burst must be over well before 200
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet <= '0;
    else if (wr_stb && (addr == `CTRL_ADDR || addr == `BUF_ADDR)) quiet <= '0;
    else if (quiet != 10'h3ff) quiet <= quiet + 10'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence gap_div16;
    !sck_edge [*7];
  endsequence
  a_mode_copy: assert property (mode == $past(ctl_h[3:0]))
    else $error("mode output does not follow control");
  a_enable_pins: assert property (pins_to_port == $past(ctl_h[5]))
    else $error("pin hand-over does not follow enable");
  a_edge_select: assert property (tx_on_rising == $past(st_h[0] ^ ctl_h[4]))
    else $error("transmit edge wrong");
  a_sample_end: assert property (sample_at_end == (spi_master && $past(st_h[1])))
    else $error("sample point wrong");
  a_slew_sel: assert property (slew_ctrl_en == (i2c_any && !$past(st_h[1])))
    else $error("slew control wrong");
  a_smbus_sel: assert property (smbus_levels == (i2c_any && $past(st_h[0])))
    else $error("input levels wrong");
  a_slave_stretch: assert property ((i2c_slave && !$past(ctl_h[4]))
    |-> (sck_oe && !sck_o)) else $error("clock not held low");
  a_spi_idle: assert property ((spi_master && quiet > 10'h0c8 &&
    mode <= MODE_SPI_M_DIV16) |-> sck_o == $past(ctl_h[4]))
    else $error("serial clock idle level wrong");
  a_div16_gap: assert property ((sck_edge && mode == MODE_SPI_M_DIV16) |=> gap_div16)
    else $error("serial clock toggles too fast");
  a_read_ctrl: assert property ((rd_stb && addr == `CTRL_ADDR) |=>
    rdata[5:0] == $past(ctl_h)) else $error("control readback wrong");
endmodule
bind sync_serial_port sync_serial_port_properties chk_u (.clk, .rst_n, .addr, .wdata, .wr_stb,
  .rd_stb, .rdata, .sck_o, .sck_oe, .mode, .pins_to_port, .spi_master, .i2c_slave, .i2c_master,
  .i2c_fw_master, .tx_on_rising, .sample_at_end, .slew_ctrl_en, .smbus_levels, .sck_edge);

//--- testbench/ssp_peer.sv
`timescale 1ns/10ps
// ==========================================================
// far-side spi master: one 16-toggle frame per go pulse
module ssp_peer #(
  parameter int HALF = 3
) (
  // control
  input  wire logic clk,
  input  wire logic go,
  input  wire logic cpol,
  // pins
  output logic      sck_i,
  output logic      ss_n_i
);
  int n;
  initial begin
    sck_i = 1'b0;
    ss_n_i = 1'b1;
  end
  // clock stands still at idle level outside a frame
  always @(posedge clk) begin
    if (ss_n_i) begin
      sck_i <= cpol;
      n <= 0;
      if (go) ss_n_i <= 1'b0;
    end else begin
      n <= n + 1;
      if (n % HALF == HALF - 1) sck_i <= ~sck_i;
      if (n == 16 * HALF - 1) ss_n_i <= 1'b1;
    end
  end
endmodule

//--- testbench/sync_serial_port_tb.sv
`timescale 1ns/10ps
`include "ssp_map.svh"
module sync_serial_port_tb;
  import ssp_pkg::*;
  logic clk, rst_n, wr_stb, rd_stb, go, rx_is_data, tx_is_data, addr_rw, sck_i, ss_n_i;
  logic [7:0] addr, wdata, rdata, rx_byte, tx_byte, ev;
  logic rx_valid, tx_done, start_det, stop_det, addr_match, nack_det, ua_req, timer2_tick;
  logic sck_o, sck_oe, pins_to_port, spi_master, spi_slave, i2c_slave, i2c_master;
  logic i2c_fw_master, ten_bit_addr, start_stop_irq_en, slave_selected, sck_level;
  logic tx_on_rising, sample_at_end, slew_ctrl_en, smbus_levels, tx_load, sck_edge;
  logic i2c_baud_tick;
  mode_t mode;
  int n_fail = 0, n_compared = 0, n_edge = 0, cyc = 0;
  assign {ua_req, nack_det, addr_match, stop_det, start_det, tx_done, rx_valid, timer2_tick} = ev;
  sync_serial_port dut_u (.clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .rx_valid,
    .rx_byte, .rx_is_data, .tx_done, .tx_is_data, .start_det, .stop_det, .addr_match,
    .addr_rw, .nack_det, .ua_req, .timer2_tick, .sck_i, .sck_o, .sck_oe, .ss_n_i, .mode,
    .pins_to_port, .spi_master, .spi_slave, .i2c_slave, .i2c_master, .i2c_fw_master,
    .ten_bit_addr, .start_stop_irq_en, .slave_selected, .sck_level, .tx_on_rising,
    .sample_at_end, .slew_ctrl_en, .smbus_levels, .tx_load, .tx_byte, .sck_edge, .i2c_baud_tick);
  ssp_peer peer_u (.clk, .go, .cpol(1'b0), .sck_i, .ss_n_i);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // bus and compare helpers
  task automatic close_out();
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    #1;
  endtask
  task automatic setmode(input logic [3:0] c, input logic p);
    wr(`CTRL_ADDR, {3'b000, p, c});
    wr(`CTRL_ADDR, {3'b001, p, c});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_modes();
    logic [7:0] e;
    for (int c = 0; c < 16; c++) begin
      setmode(4'(c), 1'b1);
      wr(`STAT_ADDR, {c[0] && c != 5, c[1], 6'h00});
      e = {c < 4, c == 4 || c == 5, c == 6 || c == 7, c == 8, c == 11 || c >= 14,
           c == 7 || c == 15, c >= 14, 1'b1};
      repeat (2) @(posedge clk);
      #1 chk({spi_master, spi_slave, i2c_slave, i2c_master, i2c_fw_master, ten_bit_addr,
              start_stop_irq_en, pins_to_port}, e);
      chk({4'h0, mode}, 8'(c));
    end
  endtask
  task automatic t_spi_master();
    setmode(4'h1, 1'b1);
    wr(`BUF_ADDR, 8'ha5);
    #1 chk({tx_load, 7'h0}, 8'h80);
    chk(tx_byte, 8'ha5);
    n_edge = 0;
    wr(`BUF_ADDR, 8'h5a);
    rd(`CTRL_ADDR, 8'hb1, 8'hff);
    repeat (220) @(posedge clk);
    #1 chk(8'(n_edge), 8'h10);
    chk({7'h0, sck_o}, 8'h01);
    wr(`CTRL_ADDR, 8'h31);
    rd(`CTRL_ADDR, 8'h31, 8'hff);
    rx_byte <= 8'h11;
    pulse(8'h02);
    rx_byte <= 8'h22;
    pulse(8'h02);
    rd(`CTRL_ADDR, 8'h31, 8'hff);
    rd(`BUF_ADDR, 8'h22, 8'hff);
  endtask
  task automatic t_i2c_slave();
    setmode(4'h6, 1'b1);
    wr(`STAT_ADDR, 8'h00);
    pulse(8'h08);
    rd(`STAT_ADDR, 8'h08, 8'hff);
    addr_rw <= 1'b1;
    pulse(8'h20);
    rd(`STAT_ADDR, 8'h0c, 8'hff);
    rx_byte <= 8'h3c;
    pulse(8'h02);
    rd(`STAT_ADDR, 8'h0d, 8'hff);
    rx_byte <= 8'hc3;
    pulse(8'h02);
    rd(`CTRL_ADDR, 8'h76, 8'hff);
    rd(`BUF_ADDR, 8'h3c, 8'hff);
    rd(`STAT_ADDR, 8'h00, 8'h01);
    pulse(8'h10);
    rd(`STAT_ADDR, 8'h10, 8'h18);
    wr(`CTRL_ADDR, 8'h16);
    rd(`STAT_ADDR, 8'h00, 8'h18);
    setmode(4'h6, 1'b1);
    wr(`BUF_ADDR, 8'h77);
    wr(`BUF_ADDR, 8'h88);
    rd(`CTRL_ADDR, 8'h80, 8'h80);
    rd(`STAT_ADDR, 8'h01, 8'h01);
    tx_is_data <= 1'b1;
    pulse(8'h04);
    rd(`STAT_ADDR, 8'h20, 8'h21);
  endtask
  task automatic t_i2c_misc();
    int k;
    setmode(4'h7, 1'b0);
    repeat (2) @(posedge clk);
    #1 chk({6'h0, sck_oe, sck_o}, 8'h02);
    pulse(8'h80);
    rd(`STAT_ADDR, 8'h02, 8'h02);
    wr(`BAUD_ADDR, 8'h03);
    rd(`STAT_ADDR, 8'h00, 8'h02);
    setmode(4'h8, 1'b0);
    for (k = 0; k < 40 && !i2c_baud_tick; k++) @(posedge clk) #1;
    for (k = 1; k < 40; k++) @(posedge clk) #1 if (i2c_baud_tick) break;
    chk(8'(k), 8'h08);
    wr(`SEQ_ADDR, 8'h01);
    wr(`BUF_ADDR, 8'h11);
    rd(`CTRL_ADDR, 8'h80, 8'h80);
    wr(`SEQ_ADDR, 8'h00);
  endtask
  task automatic t_spi_slave();
    setmode(4'h4, 1'b0);
    rx_byte <= 8'h41;
    pulse(8'h02);
    rx_byte <= 8'h42;
    pulse(8'h02);
    rd(`CTRL_ADDR, 8'h40, 8'h40);
    rd(`BUF_ADDR, 8'h41, 8'hff);
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk({6'h0, slave_selected, sck_level}, 8'h03);
    repeat (60) @(posedge clk);
    #1 chk({6'h0, slave_selected, sck_level}, 8'h00);
    setmode(4'h5, 1'b0);
    repeat (4) @(posedge clk);
    #1 chk({7'h0, slave_selected}, 8'h01);
  endtask
  // ==========================================================
  // main sequence and hang guard
  always @(posedge clk) begin
    if (sck_edge) n_edge <= n_edge + 1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    {rst_n, wr_stb, rd_stb, go, rx_is_data, tx_is_data, addr_rw} = '0;
    {addr, wdata, rx_byte, ev} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CTRL_ADDR, 8'h00, 8'hff);
    rd(`STAT_ADDR, 8'h00, 8'hff);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00, 8'hff);
    t_modes();
    t_spi_master();
    t_i2c_slave();
    t_i2c_misc();
    t_spi_slave();
    close_out();
  end
endmodule
